//--- hdl/sbsc_sram.sv
`timescale 1ns/1ps
`include "sbsc_defines.svh"
// Overview of operation
// - all synchronous inputs are sampled on the rising clock edge
// - burst order pin low selects linear, high selects interleaved order
// - flow-through pin low loads the output register directly, high adds a pipeline stage before it
// - sleep low runs normally, sleep high puts the device in standby
// - unconnected flow-through pin means pipeline, unconnected sleep means active
// - linear order counts low address bits modulo four, wrapping after four
// - the two lowest address bits also preset the burst counter
// - one active-low write enable per byte lane, four lanes
// - lane write enable writes every lane whose own enable is low
// - global write enable writes all byte lanes
// - selected only with both low enables low and high enable high
// - burst counter advances only when the advance input is low
// - processor or cache strobe loads an external address and starts a burst
// - data drivers enabled only while output enable is low
// - processor strobe with first enable low, or cache strobe, starts a burst
// - no strobe with advance low continues, advance high suspends
// - global write ignores lane and byte write enables
// - reads with output enable high still advance the counter
module sbsc_sram
	import sbsc_pkg::*;
(
	// clock and reset
	input  wire logic              CLK_I,
	input  wire logic              RESETN_I,
	// mode pins, already resolved for pull-up and pull-down
	input  wire sbsc_pkg::sbsc_mode_s MODE_I,
	// synchronous controls
	input  wire sbsc_pkg::sbsc_ctrl_s CTRL_I,
	input  wire sbsc_pkg::sbsc_addr_t ADDR_I,
	input  wire logic              OUT_ENABLE_N_I,
	// data bus as three signals
	input  wire sbsc_pkg::sbsc_data_t DATA_I,
	output sbsc_pkg::sbsc_data_t   DATA_O,
	output logic                   DATA_OE_O,
	// status
	output logic                   STANDBY_O
);
	import sbsc_pkg::*;

	sbsc_mode_s  mode_m_q, mode_q;
	logic        oe_n_m_q, oe_n_q;
	sbsc_addr_t  base_q, base_d;
	sbsc_op_e    op_q, op_d;
	sbsc_data_t  rd_data_q, rd_data_d;
	logic        rd_vld_q, rd_vld_d;
	sbsc_data_t  dout_q, dout_d;
	logic        oe_q, oe_d;
	logic        stby_q, stby_d;
	logic        sel, load, step, active, wr_req;
	logic        proc_strb, strobe, desel, access;
	logic        wr_cyc, rd_cyc;
	sbsc_lane_t  lane_we;
	logic [1:0]  low_addr;
	sbsc_addr_t  rd_addr;
	wire sbsc_data_t rd_word;

	// async mode pins pass two flip-flops
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			mode_m_q <= '{linear_order_n: 1'b0, flowthru_n: 1'b1, sleep_req: 1'b0};
			mode_q   <= '{linear_order_n: 1'b0, flowthru_n: 1'b1, sleep_req: 1'b0};
			oe_n_m_q <= 1'b1;
			oe_n_q   <= 1'b1;
		end else begin
			mode_m_q <= MODE_I;
			mode_q   <= mode_m_q;
			oe_n_m_q <= OUT_ENABLE_N_I;
			oe_n_q   <= oe_n_m_q;
		end
	end

	assign active = !mode_q.sleep_req;
	assign sel = !CTRL_I.chip_sel_low_first && CTRL_I.chip_sel_high
		&& !CTRL_I.chip_sel_low_alt;
	// processor strobe only counts while the first low enable is low
	assign proc_strb = !CTRL_I.proc_addr_strobe_n && !CTRL_I.chip_sel_low_first;
	assign strobe    = proc_strb || !CTRL_I.cache_addr_strobe_n;
	assign load  = active && sel && strobe;
	// a strobe while deselected ends the burst
	assign desel = !sel && strobe;
	assign step  = active && !strobe && !CTRL_I.burst_step_n && op_q != SBSC_IDLE;
	assign lane_we = !CTRL_I.all_lanes_write_n ? {`SBSC_LANES{1'b1}}
		: (!CTRL_I.lane_write_enable_n ? ~CTRL_I.lane_write_n : '0);
	// processor strobe always begins a read
	assign wr_req = (|lane_we) && !proc_strb;
	// deselect cycles touch neither the array nor the bus
	assign access = active && (load || (op_q != SBSC_IDLE && !desel));
	assign wr_cyc = access && wr_req;
	assign rd_cyc = access && !wr_cyc;

	sbsc_burst_counter u_cnt (
		.clk_i      (CLK_I),
		.resetn_i   (RESETN_I),
		.load_i     (load),
		.step_i     (step),
		.linear_i   (!mode_q.linear_order_n),
		.start_i    (ADDR_I[1:0]),
		.low_addr_o (low_addr)
	);

	// low pair is the address in use this cycle: preset, next or current
	assign rd_addr = {load ? ADDR_I[`SBSC_ADDR_W-1:2] : base_q[`SBSC_ADDR_W-1:2], low_addr};

	always_comb begin
		base_d = base_q;
		op_d   = op_q;
		stby_d = !active;
		if (!active) begin
			op_d = SBSC_IDLE;
		end else if (load) begin
			base_d = ADDR_I;
			op_d   = wr_req ? SBSC_WRITE : SBSC_READ;
		end else if (desel) begin
			op_d = SBSC_IDLE;
		end else if (op_q != SBSC_IDLE) begin
			op_d = (|lane_we) ? SBSC_WRITE : SBSC_READ;
		end
	end

	// pipeline adds one stage, flow-through loads the output directly
	always_comb begin
		rd_data_d = rd_data_q;
		rd_vld_d  = rd_cyc;
		dout_d    = dout_q;
		oe_d      = 1'b0;
		if (rd_cyc) begin
			rd_data_d = rd_word;
		end
		if (!mode_q.flowthru_n) begin
			if (rd_cyc) begin
				dout_d = rd_word;
			end
			oe_d = rd_cyc;
		end else begin
			if (rd_vld_q) begin
				dout_d = rd_data_q;
			end
			oe_d = rd_vld_q;
		end
		// drivers follow output enable; writes and deselects float the bus
		oe_d = oe_d && !oe_n_q && !wr_cyc && !desel;
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			base_q <= '0;
			op_q   <= SBSC_IDLE;
			rd_data_q <= '0;
			rd_vld_q  <= 1'b0;
			dout_q <= '0;
			oe_q   <= 1'b0;
			stby_q <= 1'b0;
		end else begin
			base_q <= base_d;
			op_q   <= op_d;
			rd_data_q <= rd_data_d;
			rd_vld_q  <= rd_vld_d;
			dout_q <= dout_d;
			oe_q   <= oe_d;
			stby_q <= stby_d;
		end
	end

	// lane writes at the address in use
	for (genvar l = 0; l < `SBSC_LANES; l++) begin : g_lane
		// each lane owns its storage so no two processes share a write target
		logic [`SBSC_LANE_W-1:0] lane_mem_q [0:`SBSC_DEPTH-1];
		always_ff @(posedge CLK_I) begin
			if (wr_cyc && lane_we[l]) begin
				lane_mem_q[rd_addr] <= DATA_I[l*`SBSC_LANE_W +: `SBSC_LANE_W];
			end
		end
		assign rd_word[l*`SBSC_LANE_W +: `SBSC_LANE_W] = lane_mem_q[rd_addr];
	end

	assign DATA_O    = dout_q;
	assign DATA_OE_O = oe_q;
	assign STANDBY_O = stby_q;

	property p_write_hiz;
		@(posedge CLK_I) disable iff (!RESETN_I) wr_cyc |=> !oe_q;
	endproperty
	a_write_hiz: assert property (p_write_hiz) else $error("drivers on after write");

	property p_sleep;
		@(posedge CLK_I) disable iff (!RESETN_I) !active |=> op_q == SBSC_IDLE && stby_q;
	endproperty
	a_sleep: assert property (p_sleep) else $error("not idle in standby");

	property p_gw;
		@(posedge CLK_I) disable iff (!RESETN_I) !CTRL_I.all_lanes_write_n |-> &lane_we;
	endproperty
	a_gw: assert property (p_gw) else $error("global write missed a lane");

	property p_load;
		@(posedge CLK_I) disable iff (!RESETN_I) load |-> low_addr == ADDR_I[1:0];
	endproperty
	a_load: assert property (p_load) else $error("counter not preset");

	property p_hold;
		@(posedge CLK_I) disable iff (!RESETN_I)
			(!load && !step && $stable(mode_q.linear_order_n)) |-> low_addr == $past(low_addr);
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved without advance");

	property p_desel;
		@(posedge CLK_I) disable iff (!RESETN_I)
			(desel && active) |=> op_q == SBSC_IDLE && !oe_q;
	endproperty
	a_desel: assert property (p_desel) else $error("burst while deselected");

	property p_lin;
		@(posedge CLK_I) disable iff (!RESETN_I)
			(step && !mode_q.linear_order_n && $stable(mode_q.linear_order_n))
				|-> low_addr == $past(low_addr) + 2'h1;
	endproperty
	a_lin: assert property (p_lin) else $error("linear step wrong");

	property p_oe;
		@(posedge CLK_I) disable iff (!RESETN_I) oe_n_q |=> !DATA_OE_O;
	endproperty
	a_oe: assert property (p_oe) else $error("driving with output enable high");
endmodule

//--- pkg/sbsc_defines.svh
`ifndef SBSC_DEFINES_SVH
`define SBSC_DEFINES_SVH
`define SBSC_ADDR_W     16
`define SBSC_LANES      4
`define SBSC_LANE_W     9
`define SBSC_DATA_W     36
`define SBSC_DEPTH      65536
`define SBSC_CNT_RST    2'h0
`endif

//--- pkg/sbsc_pkg.sv
`include "sbsc_defines.svh"
package sbsc_pkg;
	typedef logic [`SBSC_ADDR_W-1:0] sbsc_addr_t;
	typedef logic [`SBSC_DATA_W-1:0] sbsc_data_t;
	typedef logic [`SBSC_LANES-1:0]  sbsc_lane_t;
	typedef struct packed {
		logic                    linear_order_n;
		logic                    flowthru_n;
		logic                    sleep_req;
	} sbsc_mode_s;
	typedef struct packed {
		logic       chip_sel_low_first;
		logic       chip_sel_high;
		logic       chip_sel_low_alt;
		logic       proc_addr_strobe_n;
		logic       cache_addr_strobe_n;
		logic       burst_step_n;
		logic       all_lanes_write_n;
		logic       lane_write_enable_n;
		sbsc_lane_t lane_write_n;
	} sbsc_ctrl_s;
	typedef enum logic [1:0] {SBSC_IDLE, SBSC_READ, SBSC_WRITE} sbsc_op_e;
endpackage

//--- hdl/sbsc_burst_counter.sv
`timescale 1ns/1ps
module sbsc_burst_counter (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	// control
	input  wire logic       load_i,
	input  wire logic       step_i,
	input  wire logic       linear_i,
	input  wire logic [1:0] start_i,
	// current low address pair
	output logic      [1:0] low_addr_o
);
	logic [1:0] start_q, start_d;
	logic [1:0] cnt_q, cnt_d;

	always_comb begin
		start_d = start_q;
		cnt_d   = cnt_q;
		if (load_i) begin
			start_d = start_i;
			cnt_d   = `SBSC_CNT_RST;
		end else if (step_i) begin
			// two-bit count wraps to the start value on the fifth clock
			cnt_d = cnt_q + 2'h1;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			start_q <= 2'h0;
			cnt_q   <= 2'h0;
		end else begin
			start_q <= start_d;
			cnt_q   <= cnt_d;
		end
	end

	// linear adds, interleaved xors the same count; shows the pair in use this cycle
	assign low_addr_o = linear_i ? start_d + cnt_d : start_d ^ cnt_d;
endmodule

//--- bench/sbsc_host_model.sv
`timescale 1ns/1ps
module sbsc_host_model
	import sbsc_pkg::*;
(
	// bus clock
	input  wire logic             clk_i,
	// requests to the memory
	output sbsc_pkg::sbsc_ctrl_s  ctrl_o,
	output sbsc_pkg::sbsc_addr_t  addr_o,
	output sbsc_pkg::sbsc_data_t  data_o
);
	import sbsc_pkg::*;
	logic sel = 1'b1;
	initial begin
		ctrl_o = 12'h5ff;
		addr_o = '0;
		data_o = '0;
	end
	// c holds proc strobe, cache strobe, advance, global write, lane write
	task automatic cyc(input logic [4:0] c, input logic [3:0] l, input sbsc_addr_t a,
		input sbsc_data_t d, input logic w);
		@(posedge clk_i);
		#1;
		ctrl_o <= {1'b0, sel, 1'b0, c, l};
		addr_o <= a;
		// a released bus shows the inverse of its last value
		data_o <= w ? d : ~data_o;
	endtask
endmodule

//--- bench/sbsc_sram_tb.sv
`timescale 1ns/1ps
module sbsc_sram_tb;
	import sbsc_pkg::*;
	logic       clk = 1'b0;
	logic       rst_n;
	sbsc_mode_s mode;
	sbsc_ctrl_s ctrl;
	sbsc_addr_t addr;
	sbsc_data_t din;
	sbsc_data_t dout;
	logic       oen;
	logic       oe;
	logic       stby;
	int         fails = 0;
	int         tests_run = 0;
	int         cyc_n = 0;
	sbsc_data_t mem [4];
	logic [1:0] pv;
	sbsc_data_t px [2];
	sbsc_sram u_sbsc_sram (.CLK_I(clk), .RESETN_I(rst_n), .MODE_I(mode), .CTRL_I(ctrl),
		.ADDR_I(addr), .OUT_ENABLE_N_I(oen), .DATA_I(din), .DATA_O(dout),
		.DATA_OE_O(oe), .STANDBY_O(stby));
	sbsc_host_model u_sbsc_host_model (.clk_i(clk), .ctrl_o(ctrl), .addr_o(addr), .data_o(din));
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 4000) begin
			fails = fails + 1;
			complete_run();
		end
	end
	task automatic chk(input string n, input sbsc_data_t e, input sbsc_data_t s);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic chk1(input string n, input logic e, input logic s);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %b seen %b", n, e, s);
		end
	endtask
	// pipelined read data appears one edge after the taking edge, flow-through data at the taking edge
	task automatic op(input logic [4:0] c, input logic [3:0] l, input sbsc_addr_t a,
		input sbsc_data_t d, input logic ev, input sbsc_data_t ex);
		u_sbsc_host_model.cyc(c, l, a, d, !c[1] || !c[0]);
		// flow-through answers one edge earlier than pipeline
		if (mode.flowthru_n ? pv[1] : pv[0])
			chk("DATA_O", mode.flowthru_n ? px[1] : px[0], dout);
		pv = {pv[0], ev};
		px[1] = px[0];
		px[0] = ex;
	endtask
	task automatic flush;
		repeat (2) op(5'h1f, 4'hf, '0, '0, 1'b0, '0);
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		mode = 3'b010;
		oen = 1'b0;
		pv = '0;
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (3) @(posedge clk);
		// global write burst with lane enables all off
		for (int i = 0; i < 4; i++) begin
			mem[i] = 36'h9_1357_9bdf ^ {9{i[3:0]}};
			op(i ? 5'b11001 : 5'b10101, 4'hf, i ? 16'h7 : 16'h0, mem[i], 1'b0, '0);
		end
		for (int i = 0; i < 5; i++)
			op(i ? 5'b11011 : 5'b01111, 4'hf, 16'h2, '0, 1'b1, mem[(i + 2) % 4]);
		op(5'b11111, 4'hf, 16'h1, '0, 1'b1, mem[2]);
		flush;
		mode.linear_order_n = 1'b1;
		flush;
		for (int i = 0; i < 4; i++)
			op(i ? 5'b11011 : 5'b10111, 4'hf, 16'h1, '0, 1'b1, mem[1 ^ i]);
		mode.linear_order_n = 1'b0;
		op(5'b10110, 4'b1010, 16'h3, '0, 1'b0, '0);
		mem[3] = mem[3] & {9'h1ff, 9'h0, 9'h1ff, 9'h0};
		u_sbsc_host_model.sel = 1'b0;
		op(5'b10101, 4'hf, 16'h0, '1, 1'b0, '0);
		u_sbsc_host_model.sel = 1'b1;
		op(5'b10111, 4'hf, 16'h3, '0, 1'b1, mem[3]);
		op(5'b10111, 4'hf, 16'h0, '0, 1'b1, mem[0]);
		flush;
		chk1("DATA_OE_O", 1'b1, oe);
		oen = 1'b1;
		op(5'b10111, 4'hf, 16'h0, '0, 1'b0, '0);
		op(5'b11011, 4'hf, 16'h0, '0, 1'b0, '0);
		flush;
		flush;
		chk1("DATA_OE_O", 1'b0, oe);
		oen = 1'b0;
		op(5'b11011, 4'hf, 16'h0, '0, 1'b1, mem[2]);
		flush;
		mode.sleep_req = 1'b1;
		flush;
		flush;
		chk1("STANDBY_O", 1'b1, stby);
		mode.sleep_req = 1'b0;
		flush;
		flush;
		chk1("STANDBY_O", 1'b0, stby);
		mode.flowthru_n = 1'b0;
		flush;
		op(5'b10111, 4'hf, 16'h1, '0, 1'b1, mem[1]);
		flush;
		complete_run();
	end
endmodule
